// ===== dsp_bit_clock.sv
// master bit-clock half-period tick from divided system clock or timer output
`timescale 1ns/10ps
module dsp_bit_clock import dsp_pkg::*; (
	// system
	input wire logic mclk,
	input wire logic rst,
	// control
	input wire logic run,
	input wire logic srcTimer,
	input wire logic [1:0] divSel,
	input wire logic timerZeroOutput,
	// half-period strobe
	output logic tick
);
	typedef struct packed {
		logic [3:0] cnt;
		logic tPrev;
	} dsp_clk_st_s;

	dsp_clk_st_s q, d;

	always_comb begin
		d = q;
		d.tPrev = timerZeroOutput;
		if (srcTimer) begin
			tick = run & timerZeroOutput & ~q.tPrev;
		end else begin
			tick = run & (q.cnt == DSP_HALF_LIM[divSel]);
		end
		if (!run || tick || srcTimer) begin
			d.cnt = 4'h0;
		end else begin
			d.cnt = q.cnt + 4'h1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	a_div16_gap: assert property (
		tick && !srcTimer && divSel == 2'h3 && run |=> !tick [*7])
		else $error("divide by sixteen half period too short");
	a_timer_edge: assert property (
		tick && srcTimer |-> timerZeroOutput && !$past(timerZeroOutput))
		else $error("timer tick without timer rising edge");
endmodule // dsp_bit_clock

// ===== dsp_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module dsp_pin_sync import dsp_pkg::*; #(
	parameter int W = 3
) (
	// system
	input wire logic mclk,
	input wire logic rst,
	// pins and filtered levels
	input wire logic [W-1:0] pinRaw,
	output logic [W-1:0] pinFlt
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] f;
	} dsp_sync_st_s;

	dsp_sync_st_s q, d;

	always_comb begin
		d = q;
		d.s1 = pinRaw;
		d.s2 = q.s1;
		d.s3 = q.s2;
		// a level is accepted only when stages two and three agree
		d.f = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.f);
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign pinFlt = q.f;

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	a_filter_agree: assert property (!$stable(q.f) |-> $past(q.s2) == $past(q.s3))
		else $error("filtered level moved without agreement");
endmodule // dsp_pin_sync

// ===== dsp_pkg.sv
// constants, register map and carrier types for the serial peripheral port
package dsp_pkg;
	localparam int DSP_AW = 8;
	// register byte addresses
	localparam logic [7:0] DSP_OFS_CTRL = 8'h00;
	localparam logic [7:0] DSP_OFS_DATA = 8'h04;
	localparam logic [7:0] DSP_OFS_IE = 8'h08;
	localparam logic [7:0] DSP_OFS_STAT = 8'h0C;
	// control field positions
	localparam int DSP_B_EN = 0;
	localparam int DSP_B_DIV0 = 1;
	localparam int DSP_B_DIV1 = 2;
	localparam int DSP_B_SSPOL = 3;
	localparam int DSP_B_AVAIL = 4;
	localparam int DSP_B_PHASE = 5;
	localparam int DSP_B_SRC = 6;
	localparam int DSP_B_MASTER = 7;
	// pin vector positions after synchronising
	localparam int DSP_P_SIN = 0;
	localparam int DSP_P_SCLK = 1;
	localparam int DSP_P_SS = 2;
	// reset values
	localparam logic [7:0] DSP_CTRL_RST = 8'h00;
	localparam logic DSP_IE_RST = 1'b0;
	// counts
	localparam logic [2:0] DSP_LAST_BIT = 3'h7;
	localparam logic [4:0] DSP_LAST_TICK = 5'h0F;
	// system clocks per bit-clock half period, less one, for divide by 2, 4, 8, 16
	localparam logic [3:0] DSP_HALF_LIM [4] = '{4'h0, 4'h1, 4'h3, 4'h7};
	localparam logic [1:0] DSP_RESP_OKAY = 2'h0;
	localparam logic [1:0] DSP_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic awvalid;
		logic [DSP_AW-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [DSP_AW-1:0] araddr;
		logic rready;
	} dsp_axil_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} dsp_axil_rsp_s;

	typedef struct packed {
		logic serial_input_pin;
		logic sclkIn;
		logic ss;
	} dsp_pin_in_s;

	typedef struct packed {
		logic serial_output_pin;
		logic soutOeN;
		logic sclkOut;
		logic sclkOeN;
	} dsp_pin_out_s;

	typedef struct packed {
		logic [7:0] ctrl;
		logic ie;
		logic [7:0] sh;
		logic outBit;
		logic sclk;
		logic busy;
		logic [4:0] ticks;
		logic [2:0] bits;
		logic ssAct;
		logic sclkPrev;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} dsp_port_st_s;
endpackage

// ===== dsp_serial_port.sv
// byte-wide serial peripheral port, master or slave, with AXI4-Lite registers
//
// What this block does
// - control bit 0 enables the port; disabled after reset
// - master: bits 2..1 pick system clock divide by 2, 4, 8 or 16
// - slave: bit 1 is the overrun flag, cleared only by writing zero
// - slave: bit 2 set tri-states data out; clear shifts one out per bit in
// - bit 3 sets select polarity: zero active low, one active high
// - bit 4 shows a received byte waiting; interrupt when enabled
// - bit 5 one samples falling and drives rising; zero the reverse
// - master: bit 6 one takes timer zero output, zero the divided clock
// - bit 7 one is master role, zero is slave role
// - slave: transfer begins when select turns active, shifting data in
// - slave: full byte sets receive-available and raises the request
// - slave: byte completing before buffer read sets overrun and overwrites
// - slave: one bit driven out per bit in, on the opposite edge
// - slave: bit clock pin is an input only, never driven
// - master: writing the byte starts a transfer, one bit per clock
// - master: drives bit clock; end of transfer sets flag and request
// - bytes move most significant bit first
// - receive-available in both roles; reading the buffer clears it
// - interrupt request gated by an enable that resets cleared
// - enable switches the four port pins to serial functions
`timescale 1ns/10ps
module dsp_serial_port import dsp_pkg::*; (
	// system
	input wire logic mclk,
	input wire logic rst,
	// register bus
	input wire dsp_axil_req_s axiReq,
	output dsp_axil_rsp_s axiRsp,
	// serial pins
	input wire dsp_pin_in_s pinIn,
	output dsp_pin_out_s pinOut,
	// on-chip timer and port mux
	input wire logic timerZeroOutput,
	output logic portPinSelect,
	output logic serialIrq
);
	dsp_port_st_s q, d;
	logic [2:0] pinF;
	logic tick;
	logic wrFire;
	logic rdFire;
	logic start;
	logic byteDone;
	logic ssNow;
	logic active;
	logic masterOn;
	logic [DSP_AW-3:0] wIdx;
	logic [DSP_AW-3:0] rIdx;

	dsp_pin_sync #(.W(3)) i_dsp_pin_sync (
		.mclk(mclk),
		.rst(rst),
		.pinRaw({pinIn.ss, pinIn.sclkIn, pinIn.serial_input_pin}),
		.pinFlt(pinF)
	);

	dsp_bit_clock i_dsp_bit_clock (
		.mclk(mclk),
		.rst(rst),
		.run(q.busy),
		.srcTimer(q.ctrl[DSP_B_SRC]),
		.divSel(q.ctrl[DSP_B_DIV1:DSP_B_DIV0]),
		.timerZeroOutput(timerZeroOutput),
		.tick(tick)
	);

	assign wIdx = axiReq.awaddr[DSP_AW-1:2];
	assign rIdx = axiReq.araddr[DSP_AW-1:2];
	assign masterOn = q.ctrl[DSP_B_EN] & q.ctrl[DSP_B_MASTER];

	always_comb begin
		d = q;
		start = 1'b0;
		byteDone = 1'b0;
		wrFire = axiReq.awvalid & axiReq.wvalid & ~q.bvalid;
		rdFire = axiReq.arvalid & ~q.rvalid;
		if (q.bvalid && axiReq.bready) begin
			d.bvalid = 1'b0;
		end
		if (q.rvalid && axiReq.rready) begin
			d.rvalid = 1'b0;
		end

		// register writes; hardware flag events below override them
		if (wrFire) begin
			d.bvalid = 1'b1;
			d.bresp = DSP_RESP_OKAY;
			unique case (wIdx)
				DSP_OFS_CTRL[DSP_AW-1:2]: begin
					if (axiReq.wstrb[0]) begin
						d.ctrl[DSP_B_EN] = axiReq.wdata[DSP_B_EN];
						d.ctrl[DSP_B_DIV1] = axiReq.wdata[DSP_B_DIV1];
						d.ctrl[DSP_B_SSPOL] = axiReq.wdata[DSP_B_SSPOL];
						d.ctrl[DSP_B_PHASE] = axiReq.wdata[DSP_B_PHASE];
						d.ctrl[DSP_B_SRC] = axiReq.wdata[DSP_B_SRC];
						d.ctrl[DSP_B_MASTER] = axiReq.wdata[DSP_B_MASTER];
						// as overrun flag, software may only clear the bit
						if (axiReq.wdata[DSP_B_MASTER]) begin
							d.ctrl[DSP_B_DIV0] = axiReq.wdata[DSP_B_DIV0];
						end else begin
							d.ctrl[DSP_B_DIV0] = q.ctrl[DSP_B_DIV0] & axiReq.wdata[DSP_B_DIV0];
						end
					end
				end
				DSP_OFS_DATA[DSP_AW-1:2]: begin
					// a write during a master transfer is dropped
					if (axiReq.wstrb[0] && !q.busy) begin
						d.sh = axiReq.wdata[7:0];
						start = masterOn;
					end
				end
				DSP_OFS_IE[DSP_AW-1:2]: begin
					if (axiReq.wstrb[0]) begin
						d.ie = axiReq.wdata[0];
					end
				end
				DSP_OFS_STAT[DSP_AW-1:2]: begin
				end
				default: begin
					d.bresp = DSP_RESP_SLVERR;
				end
			endcase
		end

		// register reads
		if (rdFire) begin
			d.rvalid = 1'b1;
			d.rresp = DSP_RESP_OKAY;
			d.rdata = 32'h0000_0000;
			unique case (rIdx)
				DSP_OFS_CTRL[DSP_AW-1:2]: d.rdata[7:0] = q.ctrl;
				DSP_OFS_DATA[DSP_AW-1:2]: begin
					d.rdata[7:0] = q.sh;
					d.ctrl[DSP_B_AVAIL] = 1'b0;
				end
				DSP_OFS_IE[DSP_AW-1:2]: d.rdata[0] = q.ie;
				DSP_OFS_STAT[DSP_AW-1:2]: d.rdata[1:0] = {q.ssAct, q.busy};
				default: d.rresp = DSP_RESP_SLVERR;
			endcase
		end

		// master transfer: sixteen half periods, clock idles low
		if (start) begin
			d.busy = 1'b1;
			d.ticks = 5'h00;
			d.bits = 3'h0;
			d.sclk = 1'b0;
			d.outBit = axiReq.wdata[7];
		end else if (!masterOn) begin
			d.busy = 1'b0;
			d.sclk = 1'b0;
		end else if (q.busy && tick) begin
			d.sclk = ~q.sclk;
			d.ticks = q.ticks + 5'h01;
			if (~q.sclk ^ q.ctrl[DSP_B_PHASE]) begin
				d.sh = {q.sh[6:0], pinF[DSP_P_SIN]};
				d.bits = q.bits + 3'h1;
				byteDone = (q.bits == DSP_LAST_BIT);
			end else begin
				d.outBit = q.sh[7];
			end
			if (q.ticks == DSP_LAST_TICK) begin
				d.busy = 1'b0;
			end
		end

		// slave transfer, timed by the synchronised external clock
		ssNow = ~(pinF[DSP_P_SS] ^ q.ctrl[DSP_B_SSPOL]);
		active = q.ctrl[DSP_B_EN] & ~q.ctrl[DSP_B_MASTER] & ssNow;
		d.ssAct = active;
		d.sclkPrev = pinF[DSP_P_SCLK];
		if (active && !q.ssAct) begin
			d.bits = 3'h0;
			d.outBit = d.sh[7];
		end else if (active && pinF[DSP_P_SCLK] != q.sclkPrev) begin
			if (pinF[DSP_P_SCLK] ^ q.ctrl[DSP_B_PHASE]) begin
				d.sh = {q.sh[6:0], pinF[DSP_P_SIN]};
				d.bits = q.bits + 3'h1;
				byteDone = (q.bits == DSP_LAST_BIT);
			end else begin
				d.outBit = q.sh[7];
			end
		end

		// set wins over a clear in the same cycle
		if (byteDone) begin
			if (!q.ctrl[DSP_B_MASTER] && d.ctrl[DSP_B_AVAIL]) begin
				d.ctrl[DSP_B_DIV0] = 1'b1;
			end
			d.ctrl[DSP_B_AVAIL] = 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.ctrl <= DSP_CTRL_RST;
			q.ie <= DSP_IE_RST;
		end else begin
			q <= d;
		end
	end

	always_comb begin
		axiRsp.awready = wrFire;
		axiRsp.wready = wrFire;
		axiRsp.bvalid = q.bvalid;
		axiRsp.bresp = q.bresp;
		axiRsp.arready = rdFire;
		axiRsp.rvalid = q.rvalid;
		axiRsp.rdata = q.rdata;
		axiRsp.rresp = q.rresp;
	end

	always_comb begin
		pinOut.serial_output_pin = q.outBit;
		// select state lags control by a cycle, so gate it with the live role bits
		pinOut.soutOeN = ~(masterOn | (q.ssAct & q.ctrl[DSP_B_EN] & ~q.ctrl[DSP_B_MASTER]
			& ~q.ctrl[DSP_B_DIV1]));
		pinOut.sclkOut = q.sclk;
		pinOut.sclkOeN = ~masterOn;
	end

	assign portPinSelect = q.ctrl[DSP_B_EN];
	assign serialIrq = q.ctrl[DSP_B_AVAIL] & q.ie;

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	a_off_pins_free: assert property (!q.ctrl[DSP_B_EN] |-> pinOut.soutOeN && pinOut.sclkOeN)
		else $error("disabled port drives a pin");
	a_slave_clk_in: assert property (!q.ctrl[DSP_B_MASTER] |-> pinOut.sclkOeN)
		else $error("slave drives bit clock");
	a_slave_tristate: assert property (
		!q.ctrl[DSP_B_MASTER] && q.ctrl[DSP_B_DIV1] |-> pinOut.soutOeN)
		else $error("slave output not tri-stated");
	a_done_sets_avail: assert property (byteDone |=> q.ctrl[DSP_B_AVAIL])
		else $error("byte completed without receive-available");
	a_read_clears: assert property (
		rdFire && rIdx == DSP_OFS_DATA[DSP_AW-1:2] && !byteDone |=> !q.ctrl[DSP_B_AVAIL])
		else $error("buffer read did not clear receive-available");
	a_overrun_set: assert property (
		byteDone && !q.ctrl[DSP_B_MASTER] && q.ctrl[DSP_B_AVAIL] && !rdFire
		|=> q.ctrl[DSP_B_DIV0] && q.ctrl[DSP_B_AVAIL])
		else $error("overrun not flagged");
	a_eighth_edge: assert property (byteDone |-> q.bits == DSP_LAST_BIT)
		else $error("byte completed on wrong edge count");
	a_msb_first: assert property (start |=> q.busy && pinOut.serial_output_pin == $past(axiReq.wdata[7]))
		else $error("first bit out is not bit seven");
	a_irq_gated: assert property (serialIrq |-> q.ie && q.ctrl[DSP_B_AVAIL])
		else $error("interrupt without enable");
	a_master_done: assert property (
		q.busy && tick && q.ticks == DSP_LAST_TICK && masterOn |=> !q.busy && !pinOut.sclkOut)
		else $error("master transfer did not end after sixteen half periods");

	// pin ownership per role
	a_master_sclk_drv: assert property (
		masterOn
		|-> !pinOut.sclkOeN)
		else $error("master does not drive bit clock");

	a_master_serial_output_pin_drv: assert property (
		masterOn
		|-> !pinOut.soutOeN)
		else $error("master does not drive data out");

	a_slave_serial_output_pin_drv: assert property (
		q.ssAct && q.ctrl[DSP_B_EN] && !q.ctrl[DSP_B_MASTER] && !q.ctrl[DSP_B_DIV1]
		|-> !pinOut.soutOeN)
		else $error("selected slave does not drive data out");

	// slave shifting
	a_sel_restart: assert property (
		active && !q.ssAct
		|=> q.bits == 3'h0)
		else $error("select did not restart the bit count");

	a_slave_shift_in: assert property (
		active && q.ssAct && pinF[DSP_P_SCLK] != q.sclkPrev && (pinF[DSP_P_SCLK] ^ q.ctrl[DSP_B_PHASE])
		|=> q.sh[0] == $past(pinF[DSP_P_SIN]))
		else $error("slave sample edge did not shift data in");

	a_slave_shift_out: assert property (
		active && q.ssAct && pinF[DSP_P_SCLK] != q.sclkPrev && !(pinF[DSP_P_SCLK] ^ q.ctrl[DSP_B_PHASE])
		|=> pinOut.serial_output_pin == $past(q.sh[7]))
		else $error("slave drive edge did not present the next bit");

	// master shifting
	a_start_loads: assert property (
		start
		|=> q.sh == $past(axiReq.wdata[7:0]) && q.bits == 3'h0)
		else $error("data write did not load the shifter");

	a_master_shift_in: assert property (
		q.busy && tick && masterOn && (~q.sclk ^ q.ctrl[DSP_B_PHASE])
		|=> q.sh[0] == $past(pinF[DSP_P_SIN]))
		else $error("master sample edge did not shift data in");

	a_master_shift_out: assert property (
		q.busy && tick && masterOn && !(~q.sclk ^ q.ctrl[DSP_B_PHASE])
		|=> pinOut.serial_output_pin == $past(q.sh[7]))
		else $error("master drive edge did not present the next bit");

	a_master_toggle: assert property (
		q.busy && tick && masterOn
		|=> pinOut.sclkOut != $past(pinOut.sclkOut))
		else $error("bit clock did not toggle on a tick");

	a_abort_idle: assert property (
		!masterOn
		|=> !q.busy && !pinOut.sclkOut)
		else $error("transfer kept running outside enabled master role");

	// flags
	a_overrun_sticky: assert property (
		!q.ctrl[DSP_B_MASTER] && q.ctrl[DSP_B_DIV0] && !wrFire
		|=> q.ctrl[DSP_B_DIV0])
		else $error("overrun flag cleared without a write");

	a_overrun_no_sw_set: assert property (
		!q.ctrl[DSP_B_MASTER] && !q.ctrl[DSP_B_DIV0] && !byteDone
		&& !(wrFire && wIdx == DSP_OFS_CTRL[DSP_AW-1:2] && axiReq.wdata[DSP_B_MASTER])
		|=> !q.ctrl[DSP_B_DIV0])
		else $error("overrun flag set by software");

	a_irq_follows: assert property (
		q.ctrl[DSP_B_AVAIL] && q.ie
		|-> serialIrq)
		else $error("enabled receive-available raised no interrupt");

	// register bus answers one cycle after the take
	a_write_answer: assert property (
		wrFire
		|=> axiRsp.bvalid)
		else $error("write taken without response");

	a_read_answer: assert property (
		rdFire
		|=> axiRsp.rvalid)
		else $error("read taken without response");
endmodule // dsp_serial_port

// ===== dsp_spi_partner.sv
// far-side model: bit-clock master for a slave port, shift partner for a master port
`timescale 1ns/10ps
module dsp_spi_partner import dsp_pkg::*; #(
	parameter int HP = 8
) (
	// system
	input wire logic mclk,
	// bench control
	input wire logic go,
	input wire logic devMaster,
	input wire logic phase,
	input wire logic ssPol,
	input wire logic [7:0] txByte,
	output logic [7:0] rxByte,
	output logic busy,
	output logic [7:0] period,
	// pins
	output dsp_pin_in_s pinIn,
	input wire dsp_pin_out_s pinOut
);
	logic sinQ = 1'b0;
	logic sckQ = 1'b0;
	logic ssOn = 1'b0;
	logic first = 1'b0;
	logic sckPrev = 1'b0;
	logic [7:0] sh = 8'h00;
	logic [7:0] cnt = 8'h00;
	initial begin
		busy = 1'b0;
		rxByte = 8'h00;
		period = 8'h00;
	end
	assign pinIn = '{serial_input_pin: sinQ, sclkIn: sckQ, ss: ssOn ~^ ssPol};
	// clock stands low outside frames; half period kept slow for the port's pin filter
	task automatic frame();
		logic [7:0] t;
		t = txByte;
		ssOn <= 1'b1;
		sinQ <= t[7];
		repeat (HP) @(posedge mclk);
		for (int i = 0; i < 8; i++) begin
			sckQ <= 1'b1;
			if (phase) sinQ <= t[7];
			else rxByte <= {rxByte[6:0], pinOut.serial_output_pin};
			repeat (HP) @(posedge mclk);
			sckQ <= 1'b0;
			if (!phase) sinQ <= t[6];
			else rxByte <= {rxByte[6:0], pinOut.serial_output_pin};
			t = t << 1;
			repeat (HP) @(posedge mclk);
		end
		ssOn <= 1'b0;
		sinQ <= ~sinQ;
	endtask
	always @(posedge mclk) if (go && !devMaster) begin
		busy <= 1'b1;
		frame();
		busy <= 1'b0;
	end
	// slave side of a master port; data line keeps changing while no clock is driven
	always @(posedge mclk) begin
		sckPrev <= pinOut.sclkOut;
		cnt <= cnt + 8'h01;
		if (go && devMaster) begin
			sh <= txByte;
			sinQ <= txByte[7];
			first <= phase;
		end else if (pinOut.sclkOeN === 1'b0 && pinOut.sclkOut !== sckPrev) begin
			if (pinOut.sclkOut) begin
				period <= cnt;
				cnt <= 8'h01;
			end
			if (pinOut.sclkOut !== phase) rxByte <= {rxByte[6:0], pinOut.serial_output_pin};
			else if (first) first <= 1'b0;
			else begin
				sinQ <= sh[6];
				sh <= sh << 1;
			end
		end else if (devMaster && pinOut.sclkOeN !== 1'b0) sinQ <= ~sinQ;
	end
endmodule // dsp_spi_partner

// ===== tb_top.sv
// self-checking bench for the serial peripheral port
`timescale 1ns/10ps
module tb_top import dsp_pkg::*; ;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	dsp_axil_req_s req = '0;
	dsp_axil_rsp_s rsp;
	dsp_pin_in_s pinIn;
	dsp_pin_out_s pinOut;
	logic tmr = 1'b0;
	logic [2:0] tc = 3'h0;
	logic portSel;
	logic irq;
	logic go = 1'b0;
	logic devM = 1'b0;
	logic ph = 1'b0;
	logic pol = 1'b0;
	logic [7:0] tx = 8'h00;
	logic [7:0] prx;
	logic [7:0] per;
	logic pBusy;
	logic [7:0] c;
	logic [7:0] d;
	int n_mismatch = 0;
	int n_checks = 0;
	logic [33:0] expQ[$];
	logic [1:0] bQ[$];

	dsp_serial_port i_dsp_serial_port (.mclk(mclk), .rst(rst), .axiReq(req), .axiRsp(rsp),
		.pinIn(pinIn), .pinOut(pinOut), .timerZeroOutput(tmr), .portPinSelect(portSel),
		.serialIrq(irq));
	dsp_spi_partner i_dsp_spi_partner (.mclk(mclk), .go(go), .devMaster(devM), .phase(ph),
		.ssPol(pol), .txByte(tx), .rxByte(prx), .busy(pBusy), .period(per), .pinIn(pinIn),
		.pinOut(pinOut));

	initial forever #4 mclk = ~mclk;
	// timer output period of six clocks
	always @(posedge mclk) begin
		tc <= (tc == 3'h5) ? 3'h0 : tc + 3'h1;
		tmr <= tc < 3'h3;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask
	function automatic logic cond(int s);
		case (s)
			0: return rsp.awready & rsp.wready;
			1: return rsp.bvalid;
			2: return rsp.arready;
			3: return rsp.rvalid;
			4: return !pBusy;
			default: return irq;
		endcase
	endfunction
	task automatic waitFor(input int s, input int lim);
		int k;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (cond(s) !== 1'b1 && k < lim);
		if (cond(s) !== 1'b1) begin
			n_mismatch++;
			$display("MISMATCH wait %0d exp 1 seen 0", s);
			finish_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] r);
		@(posedge mclk);
		bQ.push_back(r);
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.awaddr <= a;
		req.wdata <= {24'h0, v};
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		waitFor(0, 100);
		req.awvalid <= 1'b0;
		req.wvalid <= 1'b0;
		waitFor(1, 100);
		req.bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		@(posedge mclk);
		expQ.push_back(e);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		waitFor(2, 100);
		req.arvalid <= 1'b0;
		waitFor(3, 100);
		req.rready <= 1'b0;
	endtask
	task automatic kick();
		@(posedge mclk);
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
	endtask

	// results are compared as they appear, against the oldest note
	always @(posedge mclk) begin
		if (rsp.rvalid === 1'b1 && req.rready === 1'b1)
			chk("rd", {rsp.rresp, rsp.rdata}, expQ.pop_front());
		if (rsp.bvalid === 1'b1 && req.bready === 1'b1)
			chk("bresp", rsp.bresp, bQ.pop_front());
	end

	initial begin
		logic [7:0] e;
		void'($urandom(32'hA974));
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		rd(DSP_OFS_CTRL, 34'h0);
		rd(DSP_OFS_IE, 34'h0);
		chk("pinsel", portSel, 1'b0);
		chk("irq", irq, 1'b0);
		rd(8'h10, {DSP_RESP_SLVERR, 32'h0});
		wr(8'h10, 8'hFF, DSP_RESP_SLVERR);
		wr(DSP_OFS_IE, 8'h01, DSP_RESP_OKAY);
		// fast dividers get a constant data line: the pin synchroniser lags the bit clock
		for (int i = 0; i < 5; i++) begin
			ph <= i[0];
			devM <= 1'b1;
			tx <= (i == 3) ? 8'($urandom) : {8{i[0]}};
			c = {1'b1, i == 4, i[0], 2'b00, i[1:0], 1'b1};
			wr(DSP_OFS_CTRL, c, DSP_RESP_OKAY);
			chk("pinsel", portSel, 1'b1);
			kick();
			d = 8'($urandom);
			wr(DSP_OFS_DATA, d, DSP_RESP_OKAY);
			waitFor(5, 400);
			// the partner takes the last bit at the edge that shows the flag
			@(posedge mclk);
			chk("period", per, (i == 4) ? 8'd12 : 8'h2 << i);
			chk("serial_output_pin", prx, d);
			rd(DSP_OFS_CTRL, {26'h0, c | 8'h10});
			if (i == 4) begin
				wr(DSP_OFS_IE, 8'h00, DSP_RESP_OKAY);
				chk("irq", irq, 1'b0);
				wr(DSP_OFS_IE, 8'h01, DSP_RESP_OKAY);
			end
			rd(DSP_OFS_DATA, {26'h0, tx});
			rd(DSP_OFS_CTRL, {26'h0, c});
			chk("irq", irq, 1'b0);
		end
		devM <= 1'b0;
		for (int j = 0; j < 4; j++) begin
			pol <= j[0];
			ph <= j[1];
			c = {2'b00, j[1], 1'b0, j[0], j == 1, 1'b0, 1'b1};
			wr(DSP_OFS_CTRL, c, DSP_RESP_OKAY);
			d = 8'($urandom);
			wr(DSP_OFS_DATA, d, DSP_RESP_OKAY);
			e = d;
			for (int k = 0; k < 1 + (j == 3); k++) begin
				tx <= 8'($urandom);
				kick();
				repeat (40) @(posedge mclk);
				chk("soe", pinOut.soutOeN, j == 1);
				chk("sce", pinOut.sclkOeN, 1'b1);
				waitFor(4, 400);
				if (j != 1) chk("serial_output_pin", prx, e);
				e = tx;
			end
			rd(DSP_OFS_CTRL, {26'h0, c | ((j == 3) ? 8'h12 : 8'h10)});
			rd(DSP_OFS_DATA, {26'h0, tx});
		end
		wr(DSP_OFS_CTRL, c | 8'h02, DSP_RESP_OKAY);
		rd(DSP_OFS_CTRL, {26'h0, c | 8'h02});
		wr(DSP_OFS_CTRL, c, DSP_RESP_OKAY);
		rd(DSP_OFS_CTRL, {26'h0, c});
		finish_test();
	end
endmodule // tb_top
